/* hpi_pkg.sv */
// shared constants and carrier types of the decoder host port
package hpi_pkg;
  // register addresses on the two address lines
  localparam logic [1:0] ADDR_MSG  = 2'h0;
  localparam logic [1:0] ADDR_CTRL = 2'h1;
  localparam logic [1:0] ADDR_PCM  = 2'h2;
  localparam logic [1:0] ADDR_CMP  = 2'h3;
  // control register field positions
  localparam int CTRL_CMP_RST = 6;
  localparam int CTRL_PCM_RST = 5;
  localparam int CTRL_CMP_AF  = 4;
  localparam int CTRL_PCM_AF  = 3;
  localparam int CTRL_IN_BSY  = 2;
  localparam int CTRL_OUT_RDY = 1;
  // reset values
  localparam logic       PORT_RST_RST = 1'h0;
  localparam logic       FLAG_RST     = 1'h0;
  localparam logic [7:0] BYTE_RST     = 8'h00;
  localparam logic [6:0] DEV_ADDR_RST = 7'h00;
  // serial framing and input buffer depth
  localparam int         BYTE_BITS    = 8;
  localparam logic [2:0] BIT_PENULT   = 3'h6;
  localparam int         FIFO_DEPTH   = 16;

  typedef enum logic [1:0] {
    HPI_SER_ADDR  = 2'b00,
    HPI_SER_WRITE = 2'b01,
    HPI_SER_READ  = 2'b10,
    HPI_SER_SKIP  = 2'b11
  } hpi_ser_e;

  typedef struct packed {
    logic       compressed;
    logic [7:0] data;
  } hpi_stream_s;

  typedef struct packed {
    logic       cs_n;
    logic       strobe_n;
    logic       rnw;
    logic [1:0] addr;
    logic [7:0] data;
    logic       sclk;
    logic       sdin;
  } hpi_pins_s;
endpackage

/* hpi_fifo.sv */
// input stream buffer with valid and ready on both sides
`timescale 1ns/100ps
module hpi_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // storage
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  // pointers and fill level
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

/* hpi_top.sv */
// decoder host port: strobe parallel mode and serial slave mode
// Function
// RULE1: host bytes written at address 10b go to the buffer as pcm data
// RULE2: host bytes written at address 11b go to the buffer as compressed
// RULE3: parallel cycle active only while chip select and strobe both low
// RULE4: outbound ready sets on dsp message write, clears on host read
// RULE5: drive data bus only in an active read cycle, release at once
// RULE6: host sets direction low then strobes, giving address and byte
// RULE7: written byte is captured when the first of the two strobes rises
// RULE8: inbound busy sets on host message write, clears on dsp consume
// RULE9: serial mode is always slave; serial clock is only an input
// RULE10: host keeps chip select low for the whole serial transaction
// RULE11: serial data is valid at each rising serial clock edge
// RULE12: request line pulled low while outbound data waits for the host
// RULE13: serial write opens with 7-bit address and direction bit zero
// RULE14: own address resets to zero; mismatched data is ignored
// RULE15: serial bytes arrive msb first, any count of whole bytes
// RULE16: received byte handed on at the eighth falling serial clock edge
// RULE17: serial read opens with address, direction high, until request ends
// RULE18: serial output bit changes on falling serial clock edges
// RULE19: no more data: request released after penultimate bit rising edge
// RULE20: more data: request stays low, next byte loads after last falling
// RULE21: a loaded byte shifts out on serial clock edges while selected
// RULE22: control bits 6..1 hold port resets, almost full, busy and ready
// RULE23: message location is two separate inbound and outbound registers
// RULE24: chip select high clears bit counter and address match state
`timescale 1ns/100ps
module hpi_top #(
  parameter int FIFO_DEPTH = hpi_pkg::FIFO_DEPTH
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // mode strap, high selects serial mode
  input  wire logic       serial_mode,
  // parallel host pins
  input  wire logic       chip_sel_n,
  input  wire logic       strobe_n,
  input  wire logic       read_not_write,
  input  wire logic [1:0] addr,
  input  wire logic [7:0] data_in,
  output logic      [7:0] data_out,
  output logic            data_oe,
  // serial host pins
  input  wire logic       serial_clock_in,
  input  wire logic       serial_in,
  output logic            serial_out,
  input  wire logic       request_n_in,
  output logic            request_n_out,
  output logic            request_n_oe,
  // dsp message side
  input  wire logic       dsp_msg_wr,
  input  wire logic [7:0] dsp_msg_wdata,
  input  wire logic       dsp_msg_rd,
  output logic      [7:0] message_port_in,
  output logic            inbound_busy,
  output logic            outbound_ready,
  // dsp configuration side
  input  wire logic       dsp_addr_wr,
  input  wire logic [6:0] dsp_addr_value,
  input  wire logic       dsp_addr_check_off,
  input  wire logic       pcm_almost_full,
  input  wire logic       compressed_almost_full,
  output logic            pcm_port_reset,
  output logic            compressed_port_reset,
  // dsp input stream
  output logic            stream_valid,
  input  wire logic       stream_ready,
  output logic      [8:0] stream_data
);
  hpi_pkg::hpi_pins_s pin_raw;
  hpi_pkg::hpi_pins_s pin_m_q;
  hpi_pkg::hpi_pins_s pin_s_q;
  hpi_pkg::hpi_pins_s pin_p_q;
  logic [1:0]         mode_q;

  logic [7:0] msg_out_q;
  logic [7:0] msg_in_q;
  logic       in_bsy_q;
  logic       out_rdy_q;
  logic       pcm_rst_q;
  logic       cmp_rst_q;
  logic [6:0] dev_addr_q;
  logic       chk_off_q;

  logic       p_act;
  logic       p_act_prev;
  logic       p_wr_end;
  logic       p_rd_end;
  logic       host_wr;
  logic [1:0] host_wr_addr;
  logic [7:0] host_wr_data;
  logic       host_msg_rd;

  hpi_pkg::hpi_ser_e ser_q;
  logic [2:0] bit_cnt_q;
  logic       full_q;
  logic [7:0] rx_q;
  logic [7:0] tx_q;
  logic       sout_q;
  logic       hold_q;
  logic       s_sel;
  logic       s_rise;
  logic       s_fall;
  logic       s_byte;
  logic       s_load;
  logic       s_wr;
  logic       req_q;

  hpi_pkg::hpi_stream_s fifo_in;
  logic       fifo_in_valid;
  logic       fifo_in_ready;
  logic [7:0] rd_mux;
  logic [7:0] ctrl_rd;

  assign pin_raw = '{cs_n: chip_sel_n, strobe_n: strobe_n,
                     rnw: read_not_write, addr: addr, data: data_in,
                     sclk: serial_clock_in, sdin: serial_in};

  // two-stage pin synchronisers and an edge history stage
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_m_q <= '{cs_n: 1'b1, strobe_n: 1'b1, default: '0};
      pin_s_q <= '{cs_n: 1'b1, strobe_n: 1'b1, default: '0};
      pin_p_q <= '{cs_n: 1'b1, strobe_n: 1'b1, default: '0};
      mode_q  <= 2'h0;
    end else begin
      pin_m_q <= pin_raw;
      pin_s_q <= pin_m_q;
      pin_p_q <= pin_s_q;
      mode_q  <= {mode_q[0], serial_mode};
    end
  end

  // parallel cycle detection
  assign p_act      = ~mode_q[1] & ~pin_s_q.cs_n & ~pin_s_q.strobe_n; // [RULE3]
  assign p_act_prev = ~mode_q[1] & ~pin_p_q.cs_n & ~pin_p_q.strobe_n;
  assign p_wr_end   = p_act_prev & ~p_act & ~pin_p_q.rnw; // [RULE7]
  assign p_rd_end   = p_act_prev & ~p_act & pin_p_q.rnw;

  // serial edge detection
  assign s_sel  = mode_q[1] & ~pin_s_q.cs_n;
  assign s_rise = s_sel & pin_s_q.sclk & ~pin_p_q.sclk; // [RULE9] [RULE11]
  assign s_fall = s_sel & ~pin_s_q.sclk & pin_p_q.sclk;
  assign s_byte = s_fall & full_q; // [RULE16]
  assign s_wr   = s_byte & (ser_q == hpi_pkg::HPI_SER_WRITE);
  assign s_load = s_byte & out_rdy_q &
                  ((ser_q == hpi_pkg::HPI_SER_READ) |
                   ((ser_q == hpi_pkg::HPI_SER_ADDR) & rx_q[0] &
                    ((rx_q[7:1] == dev_addr_q) | chk_off_q)));

  // one write source: parallel address or serial message stream
  assign host_wr      = p_wr_end | s_wr;
  assign host_wr_addr = p_wr_end ? pin_p_q.addr : hpi_pkg::ADDR_MSG;
  assign host_wr_data = p_wr_end ? pin_p_q.data : rx_q;
  assign host_msg_rd  = (p_rd_end & (pin_p_q.addr == hpi_pkg::ADDR_MSG)) |
                        s_load;

  // device address configuration
  always_ff @(posedge clk) begin
    if (rst) begin
      dev_addr_q <= hpi_pkg::DEV_ADDR_RST; // [RULE14]
      chk_off_q  <= hpi_pkg::FLAG_RST;
    end else if (dsp_addr_wr) begin
      dev_addr_q <= dsp_addr_value;
      chk_off_q  <= dsp_addr_check_off;
    end
  end

  // message registers in each direction
  always_ff @(posedge clk) begin
    if (rst) begin
      msg_in_q  <= hpi_pkg::BYTE_RST;
      msg_out_q <= hpi_pkg::BYTE_RST;
    end else begin
      if (host_wr & (host_wr_addr == hpi_pkg::ADDR_MSG)) begin
        msg_in_q <= host_wr_data; // [RULE23]
      end
      if (dsp_msg_wr) begin
        msg_out_q <= dsp_msg_wdata; // [RULE23]
      end
    end
  end

  // handshake flags, set wins over clear
  always_ff @(posedge clk) begin
    if (rst) begin
      in_bsy_q  <= hpi_pkg::FLAG_RST;
      out_rdy_q <= hpi_pkg::FLAG_RST;
    end else begin
      if (host_wr & (host_wr_addr == hpi_pkg::ADDR_MSG)) begin
        in_bsy_q <= 1'b1; // [RULE8]
      end else if (dsp_msg_rd) begin
        in_bsy_q <= 1'b0; // [RULE8]
      end
      if (dsp_msg_wr) begin
        out_rdy_q <= 1'b1; // [RULE4]
      end else if (host_msg_rd) begin
        out_rdy_q <= 1'b0; // [RULE4]
      end
    end
  end

  // control register writes
  always_ff @(posedge clk) begin
    if (rst) begin
      pcm_rst_q <= hpi_pkg::PORT_RST_RST;
      cmp_rst_q <= hpi_pkg::PORT_RST_RST;
    end else if (p_wr_end & (pin_p_q.addr == hpi_pkg::ADDR_CTRL)) begin
      cmp_rst_q <= pin_p_q.data[hpi_pkg::CTRL_CMP_RST]; // [RULE22]
      pcm_rst_q <= pin_p_q.data[hpi_pkg::CTRL_PCM_RST]; // [RULE22]
    end
  end

  // control read image, reserved bits read zero
  always_comb begin
    ctrl_rd = 8'h00;
    ctrl_rd[hpi_pkg::CTRL_CMP_RST] = cmp_rst_q; // [RULE22]
    ctrl_rd[hpi_pkg::CTRL_PCM_RST] = pcm_rst_q;
    ctrl_rd[hpi_pkg::CTRL_CMP_AF]  = compressed_almost_full | ~fifo_in_ready;
    ctrl_rd[hpi_pkg::CTRL_PCM_AF]  = pcm_almost_full | ~fifo_in_ready;
    ctrl_rd[hpi_pkg::CTRL_IN_BSY]  = in_bsy_q;
    ctrl_rd[hpi_pkg::CTRL_OUT_RDY] = out_rdy_q;
  end

  // read mux, data ports are write only and read zero
  always_comb begin
    case (pin_s_q.addr)
      hpi_pkg::ADDR_MSG:  rd_mux = msg_out_q;
      hpi_pkg::ADDR_CTRL: rd_mux = ctrl_rd;
      default:            rd_mux = 8'h00;
    endcase
  end

  // parallel data bus drive
  always_ff @(posedge clk) begin
    if (rst) begin
      data_oe  <= 1'b0;
      data_out <= hpi_pkg::BYTE_RST;
    end else begin
      data_oe  <= p_act & pin_s_q.rnw; // [RULE5]
      data_out <= rd_mux;
    end
  end

  // serial receive: framing, address match and bit counter
  always_ff @(posedge clk) begin
    if (rst || !s_sel) begin
      ser_q     <= hpi_pkg::HPI_SER_ADDR; // [RULE24]
      bit_cnt_q <= 3'h0;
      full_q    <= 1'b0;
      rx_q      <= hpi_pkg::BYTE_RST;
    end else begin
      if (s_rise) begin
        rx_q      <= {rx_q[6:0], pin_s_q.sdin}; // [RULE15]
        bit_cnt_q <= bit_cnt_q + 3'h1;
        full_q    <= (bit_cnt_q == 3'(hpi_pkg::BYTE_BITS - 1));
      end else if (s_byte) begin
        full_q <= 1'b0;
        case (ser_q)
          hpi_pkg::HPI_SER_ADDR: begin
            if ((rx_q[7:1] == dev_addr_q) | chk_off_q) begin // [RULE14]
              ser_q <= rx_q[0] ? hpi_pkg::HPI_SER_READ
                               : hpi_pkg::HPI_SER_WRITE; // [RULE13] [RULE17]
            end else begin
              ser_q <= hpi_pkg::HPI_SER_SKIP;
            end
          end
          default: ser_q <= ser_q;
        endcase
      end
    end
  end

  // serial transmit shifter
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_q   <= hpi_pkg::BYTE_RST;
      sout_q <= 1'b0;
    end else if (s_load) begin
      sout_q <= msg_out_q[7]; // [RULE20]
      tx_q   <= {msg_out_q[6:0], 1'b0};
    end else if (s_fall) begin
      sout_q <= tx_q[7]; // [RULE18] [RULE21]
      tx_q   <= {tx_q[6:0], 1'b0};
    end
  end

  // request hold while a byte is in flight
  always_ff @(posedge clk) begin
    if (rst || !s_sel) begin
      hold_q <= 1'b0;
    end else if (s_load) begin
      hold_q <= 1'b1;
    end else if (s_rise & (bit_cnt_q == hpi_pkg::BIT_PENULT)) begin
      hold_q <= 1'b0; // [RULE19]
    end
  end

  // open-drain request output
  always_ff @(posedge clk) begin
    if (rst) begin
      req_q <= 1'b0;
    end else begin
      req_q <= out_rdy_q | hold_q; // [RULE12] [RULE19] [RULE20]
    end
  end

  // input stream from data ports
  assign fifo_in_valid = p_wr_end &
    (((pin_p_q.addr == hpi_pkg::ADDR_PCM) & ~pcm_rst_q) | // [RULE1]
     ((pin_p_q.addr == hpi_pkg::ADDR_CMP) & ~cmp_rst_q)); // [RULE2]
  assign fifo_in = '{compressed: pin_p_q.addr[0], data: pin_p_q.data};

  hpi_fifo #(
    .WIDTH ($bits(hpi_pkg::hpi_stream_s)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in),
    .out_valid (stream_valid),
    .out_ready (stream_ready),
    .out_data  (stream_data)
  );

  assign serial_out            = sout_q;
  assign request_n_out         = 1'b0;
  assign request_n_oe          = req_q;
  assign message_port_in       = msg_in_q;
  assign inbound_busy          = in_bsy_q;
  assign outbound_ready        = out_rdy_q;
  assign pcm_port_reset        = pcm_rst_q;
  assign compressed_port_reset = cmp_rst_q;
endmodule

/* hpi_props.sv */
// assertion checker for the decoder host port
`timescale 1ns/100ps
module hpi_props (
  // clock and reset
  input wire logic       clk,
  input wire logic       rst,
  // parallel pins
  input wire logic       serial_mode,
  input wire logic       chip_sel_n,
  input wire logic       strobe_n,
  input wire logic       read_not_write,
  input wire logic [1:0] addr,
  input wire logic [7:0] data_out,
  input wire logic       data_oe,
  // serial pins
  input wire logic       serial_clock_in,
  input wire logic       serial_out,
  input wire logic       request_n_out,
  input wire logic       request_n_oe,
  // dsp message side
  input wire logic       dsp_msg_wr,
  input wire logic       dsp_msg_rd,
  input wire logic       inbound_busy,
  input wire logic       outbound_ready
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic rd_act;
  assign rd_act = !chip_sel_n && !strobe_n && read_not_write && !serial_mode;

  oe_cause_a: assert property (data_oe |-> $past(rd_act, 3))
    else $error("data bus driven outside a read cycle");
  oe_drive_a: assert property ($past(rd_act, 3) |-> data_oe)
    else $error("data bus not driven in a read cycle");
  wo_zero_a: assert property (data_oe && $past(addr[1], 3) |->
    data_out == 8'h00) else $error("write-only port read back data");
  rdy_set_a: assert property (dsp_msg_wr |=> outbound_ready)
    else $error("outbound ready missing after dsp write");
  bsy_clr_a: assert property ($fell(inbound_busy) |-> $past(dsp_msg_rd))
    else $error("inbound busy cleared without dsp read");
  req_drive_a: assert property ($past(outbound_ready) |-> request_n_oe)
    else $error("request not pulled while data waits");
  req_cause_a: assert property ($rose(request_n_oe) |->
    $past(outbound_ready)) else $error("request pulled with nothing ready");
  open_drain_a: assert property (request_n_out == 1'b0)
    else $error("request line driven high");
  sout_fall_a: assert property ($changed(serial_out) |-> !serial_clock_in)
    else $error("serial output changed while clock high");

  cover property (data_oe ##1 !data_oe);
  cover property ($fell(request_n_oe));
  cover property ($fell(inbound_busy));
endmodule

bind hpi_top hpi_props props_u (.clk, .rst, .serial_mode, .chip_sel_n,
  .strobe_n, .read_not_write, .addr, .data_out, .data_oe, .serial_clock_in,
  .serial_out, .request_n_out, .request_n_oe, .dsp_msg_wr, .dsp_msg_rd,
  .inbound_busy, .outbound_ready);

/* hpi_host_model.sv */
// serial host model driving the link of the decoder host port
`timescale 1ns/100ps
module hpi_host_model (
  // pacing clock
  input  wire logic clk,
  // serial link
  output logic      sclk,
  output logic      sdin,
  output logic      cs_n,
  input  wire logic sout
);
  initial begin
    sclk = 1'b0;
    sdin = 1'b0;
    cs_n = 1'b1;
  end
  task automatic start();
    @(posedge clk);
    cs_n <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task automatic stop();
    repeat (4) @(posedge clk);
    cs_n <= 1'b1;
    sdin <= ~sdin;
    repeat (8) @(posedge clk);
  endtask
  // msb first; nb below 8 leaves a partial byte
  task automatic xbyte(input logic [7:0] tx, input int nb,
                       output logic [7:0] rx);
    rx = 8'h00;
    sdin <= tx[7];
    for (int i = 7; i > 7 - nb; i--) begin
      repeat (4) @(posedge clk);
      sclk <= 1'b1;
      rx[i] = sout;
      repeat (4) @(posedge clk);
      sclk <= 1'b0;
      if (i > 0) sdin <= tx[i-1];
    end
  endtask
endmodule

/* tb_top.sv */
// self-checking testbench for the decoder host port
`timescale 1ns/100ps
module tb_top;
  logic       clk = 1'b0, rst = 1'b1, serial_mode = 1'b0;
  logic       par_cs_n = 1'b1, strobe_n = 1'b1, read_not_write = 1'b0;
  logic [1:0] addr = 2'h0;
  logic [7:0] host_d = 8'h00, dsp_msg_wdata = 8'h00, q;
  logic [7:0] bus, data_out, message_port_in;
  logic       data_oe, chip_sel_n, ser_cs_n, sclk, sdin, serial_out;
  logic       req_w, request_n_out, request_n_oe;
  logic       dsp_msg_wr = 1'b0, dsp_msg_rd = 1'b0, dsp_addr_wr = 1'b0;
  logic [6:0] dsp_addr_value = 7'h05;
  logic       dsp_addr_check_off = 1'b0, stream_ready = 1'b0;
  logic       pcm_almost_full = 1'b0, compressed_almost_full = 1'b0;
  logic       inbound_busy, outbound_ready, stream_valid;
  logic       pcm_port_reset, compressed_port_reset;
  logic [8:0] stream_data;
  int         fails = 0, check_count = 0, cyc = 0;

  always #25 clk = ~clk;
  assign bus = data_oe ? data_out : host_d;
  assign chip_sel_n = serial_mode ? ser_cs_n : par_cs_n;
  assign req_w = request_n_oe ? request_n_out : 1'b1;

  hpi_top dut_u (.clk, .rst, .serial_mode, .chip_sel_n, .strobe_n,
    .read_not_write, .addr, .data_in(bus), .data_out, .data_oe,
    .serial_clock_in(sclk), .serial_in(sdin), .serial_out,
    .request_n_in(req_w), .request_n_out, .request_n_oe, .dsp_msg_wr,
    .dsp_msg_wdata, .dsp_msg_rd, .message_port_in, .inbound_busy,
    .outbound_ready, .dsp_addr_wr, .dsp_addr_value, .dsp_addr_check_off,
    .pcm_almost_full, .compressed_almost_full, .pcm_port_reset,
    .compressed_port_reset, .stream_valid, .stream_ready, .stream_data);
  hpi_host_model host_u (.clk, .sclk, .sdin, .cs_n(ser_cs_n),
    .sout(serial_out));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk({7'h00, got}, {7'h00, exp});
  endtask
  task automatic clks(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic par(input logic rnw, input logic [1:0] a,
                     input logic [7:0] d, output logic [7:0] r);
    @(posedge clk);
    read_not_write <= rnw;
    addr <= a;
    host_d <= rnw ? ~host_d : d;
    @(posedge clk);
    par_cs_n <= 1'b0;
    strobe_n <= 1'b0;
    clks(5);
    r = data_out;
    chk_bit(data_oe, rnw);
    if (a[0]) par_cs_n <= 1'b1;
    else strobe_n <= 1'b1;
    host_d <= ~host_d;
    clks(2);
    par_cs_n <= 1'b1;
    strobe_n <= 1'b1;
    clks(5);
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    par(1'b0, a, d, q);
  endtask
  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    par(1'b1, a, 8'h00, q);
    chk(q, e);
  endtask
  task automatic dsp(input logic w, input logic [7:0] d);
    @(posedge clk);
    dsp_msg_wr <= w;
    dsp_msg_rd <= !w;
    dsp_msg_wdata <= d;
    @(posedge clk);
    dsp_msg_wr <= 1'b0;
    dsp_msg_rd <= 1'b0;
  endtask
  task automatic pop(input logic c, input logic [7:0] d);
    int n = 0;
    @(posedge clk);
    stream_ready <= 1'b1;
    @(posedge clk);
    while (stream_valid !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    chk_bit(stream_valid, 1'b1);
    chk(stream_data[7:0], d);
    chk_bit(stream_data[8], c);
    stream_ready <= 1'b0;
  endtask
  task automatic swr(input logic [6:0] a, input logic [7:0] d);
    host_u.start();
    host_u.xbyte({a, 1'b0}, 8, q);
    host_u.xbyte(d, 8, q);
    host_u.stop();
  endtask
  task automatic cfg(input logic off);
    @(posedge clk);
    dsp_addr_check_off <= off;
    dsp_addr_wr <= 1'b1;
    @(posedge clk);
    dsp_addr_wr <= 1'b0;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      fails++;
      report_and_stop();
    end
  end

  initial begin
    clks(3);
    rst <= 1'b0;
    clks(4);
    chk_bit(inbound_busy | outbound_ready | request_n_oe, 1'b0);
    rd(hpi_pkg::ADDR_CTRL, 8'h00);
    wr(hpi_pkg::ADDR_MSG, 8'hA5);
    chk(message_port_in, 8'hA5);
    rd(hpi_pkg::ADDR_CTRL, 8'h04);
    dsp(1'b0, 8'h00);
    clks(1);
    chk_bit(inbound_busy, 1'b0);
    dsp(1'b1, 8'h3C);
    clks(2);
    chk_bit(req_w, 1'b0);
    rd(hpi_pkg::ADDR_CTRL, 8'h02);
    rd(hpi_pkg::ADDR_MSG, 8'h3C);
    chk_bit(outbound_ready, 1'b0);
    chk(message_port_in, 8'hA5);
    $display("test parallel message done");
    wr(hpi_pkg::ADDR_PCM, 8'h11);
    wr(hpi_pkg::ADDR_CMP, 8'h22);
    rd(hpi_pkg::ADDR_CMP, 8'h00);
    pop(1'b0, 8'h11);
    pop(1'b1, 8'h22);
    pcm_almost_full <= 1'b1;
    rd(hpi_pkg::ADDR_CTRL, 8'h08);
    pcm_almost_full <= 1'b0;
    compressed_almost_full <= 1'b1;
    rd(hpi_pkg::ADDR_CTRL, 8'h10);
    compressed_almost_full <= 1'b0;
    wr(hpi_pkg::ADDR_CTRL, 8'h60);
    chk_bit(pcm_port_reset & compressed_port_reset, 1'b1);
    wr(hpi_pkg::ADDR_PCM, 8'h33);
    wr(hpi_pkg::ADDR_CMP, 8'h44);
    chk_bit(stream_valid, 1'b0);
    wr(hpi_pkg::ADDR_CTRL, 8'h00);
    chk_bit(pcm_port_reset | compressed_port_reset, 1'b0);
    for (int i = 0; i < 17; i++) wr(hpi_pkg::ADDR_PCM, 8'(i));
    rd(hpi_pkg::ADDR_CTRL, 8'h18);
    for (int i = 0; i < 16; i++) pop(1'b0, 8'(i));
    clks(3);
    chk_bit(stream_valid, 1'b0);
    $display("test parallel stream done");
    serial_mode <= 1'b1;
    clks(5);
    host_u.start();
    host_u.xbyte(8'h00, 8, q);
    host_u.xbyte(8'h5A, 8, q);
    clks(5);
    chk(message_port_in, 8'h5A);
    host_u.xbyte(8'hC3, 8, q);
    host_u.stop();
    chk(message_port_in, 8'hC3);
    host_u.start();
    host_u.xbyte(8'h00, 8, q);
    host_u.xbyte(8'hFF, 4, q);
    host_u.stop();
    swr(7'h00, 8'h81);
    chk(message_port_in, 8'h81);
    swr(7'h05, 8'h77);
    chk(message_port_in, 8'h81);
    cfg(1'b0);
    swr(7'h05, 8'h66);
    chk(message_port_in, 8'h66);
    swr(7'h00, 8'h55);
    chk(message_port_in, 8'h66);
    cfg(1'b1);
    swr(7'h33, 8'h44);
    chk(message_port_in, 8'h44);
    $display("test serial write done");
    dsp(1'b1, 8'h96);
    clks(3);
    chk_bit(req_w, 1'b0);
    host_u.start();
    host_u.xbyte({7'h05, 1'b1}, 8, q);
    fork
      host_u.xbyte(8'h00, 8, q);
      begin
        clks(20);
        dsp(1'b1, 8'h69);
      end
    join
    chk(q, 8'h96);
    chk_bit(req_w, 1'b0);
    host_u.xbyte(8'h00, 8, q);
    chk(q, 8'h69);
    chk_bit(req_w, 1'b1);
    host_u.stop();
    chk_bit(outbound_ready, 1'b0);
    $display("test serial read done");
    report_and_stop();
  end
endmodule
